// *** logic/deser_shared_ctrl_status_regs.v ***
// shared control and status registers of the link deserializer
// assumes a local host port and a remote control-channel port, one
// request per cycle each; the rom loader and link core sit outside
`include "deser_regs_consts.vh"
module deser_shared_ctrl_status_regs #(
  parameter NPORTS = 2,
  parameter UNIT_CYCLES = `WDOG_UNIT_CYC,
  // arbitrary neutral revision value
  parameter [3:0] REV_ID = 4'h5
) (
  input wire ref_clk,
  input wire srst,
  input wire locWr,
  input wire locRd,
  input wire [7:0] locAddr,
  input wire [7:0] locWdata,
  input wire remWr,
  input wire remRd,
  input wire remLocal,
  input wire [7:0] remAddr,
  input wire [7:0] remWdata,
  output reg [7:0] readData_r,
  output reg readValid_r,
  output reg remWrRejected_r,
  output reg passThru_r,
  input wire passIn,
  input wire lockIn,
  input wire romLoadDone,
  input wire romCksumOk,
  output reg romLoadReq_r,
  input wire [NPORTS-1:0] parityErr,
  input wire [NPORTS-1:0] parityFlagClr,
  output reg [NPORTS-1:0] parityFlag_r,
  output reg parityCheckEn_r,
  input wire ccTxnActive,
  output reg ccAbort_r
);
  reg [7:0] thrHigh_r;
  reg [7:0] thrLow_r;
  reg [6:0] ctrlChannelTimeout_r;
  reg ctrlChannelTimeoutOff_r;
  reg localWrDis_r;
  reg configChecksumOk_r;
  reg initDone_r;
  reg passLat_r;
  reg lockLat_r;
  reg bootPend_r;
  reg [7:0] readData_nxt;

  wire useLoc;
  wire [7:0] acAddr;
  wire [7:0] acWdata;
  wire remLocalAcc;
  wire acWr;
  wire acRd;
  wire statusRead;
  wire [15:0] threshold;
  wire wdogAbort;
  wire [NPORTS-1:0] parityFlag_nxt;

  // local host wins a same-cycle collision; remote request is dropped
  assign useLoc = locWr | locRd;
  assign acAddr = useLoc ? locAddr : remAddr;
  assign acWdata = useLoc ? locWdata : remWdata;
  assign remLocalAcc = ~useLoc & remLocal;
  assign acWr = locWr | (remLocalAcc & remWr & ~localWrDis_r);
  assign acRd = locRd | (remLocalAcc & remRd);
  assign statusRead = acRd && (acAddr == `ADDR_STATUS);
  assign threshold = {thrHigh_r, thrLow_r};

  // writable control fields
  always @(posedge ref_clk) begin
    if (srst) begin
      parityCheckEn_r <= `RST_PARITY_EN;
      thrHigh_r <= `RST_THR_HIGH;
      thrLow_r <= `RST_THR_LOW;
      ctrlChannelTimeout_r <= `RST_WDOG_TIMEOUT;
      ctrlChannelTimeoutOff_r <= `RST_WDOG_OFF;
      localWrDis_r <= `RST_LOCAL_WR_DIS;
    end else if (acWr) begin
      case (acAddr)
        `ADDR_GEN_CFG: begin
          parityCheckEn_r <= acWdata[`BIT_PARITY_EN];
        end
        `ADDR_THR_HIGH: begin
          thrHigh_r <= acWdata;
        end
        `ADDR_THR_LOW: begin
          thrLow_r <= acWdata;
        end
        `ADDR_WDOG: begin
          ctrlChannelTimeout_r <= acWdata[7:1];
          ctrlChannelTimeoutOff_r <= acWdata[`BIT_WDOG_OFF];
        end
        `ADDR_HOST_CTL1: begin
          localWrDis_r <= acWdata[`BIT_LOCAL_WR_DIS];
        end
        default: begin
          // revision, status and unmapped addresses ignore writes
        end
      endcase
    end
  end

  // remote access routing
  always @(posedge ref_clk) begin
    if (srst) begin
      remWrRejected_r <= 1'b0;
      passThru_r <= 1'b0;
    end else begin
      remWrRejected_r <= remLocalAcc & remWr & localWrDis_r;
      // far-side target traffic never sees the write block
      passThru_r <= ~useLoc & ~remLocal & (remWr | remRd);
    end
  end

  // rom load sequencing: one request after reset and on each reload
  always @(posedge ref_clk) begin
    if (srst) begin
      bootPend_r <= 1'b1;
      romLoadReq_r <= 1'b0;
      initDone_r <= 1'b0;
      configChecksumOk_r <= 1'b0;
    end else begin
      romLoadReq_r <= 1'b0;
      if (bootPend_r) begin
        bootPend_r <= 1'b0;
        romLoadReq_r <= 1'b1;
      end else if (acWr && acAddr == `ADDR_RESET_CTRL &&
                   acWdata[`BIT_ROM_RELOAD]) begin
        // bit self-clears: it is never stored, pulses the loader and clears init done and checksum ok
        romLoadReq_r <= 1'b1;
        initDone_r <= 1'b0;
        configChecksumOk_r <= 1'b0;
      end else if (romLoadDone) begin
        initDone_r <= 1'b1;
        configChecksumOk_r <= romCksumOk;
      end
    end
  end

  // latched-high status: the level in the read cycle survives the clear
  always @(posedge ref_clk) begin
    if (srst) begin
      passLat_r <= 1'b0;
      lockLat_r <= 1'b0;
    end else if (statusRead) begin
      passLat_r <= passIn;
      lockLat_r <= lockIn;
    end else begin
      passLat_r <= passLat_r | passIn;
      lockLat_r <= lockLat_r | lockIn;
    end
  end

  // per-port parity error counters, saturating at all ones
  genvar p;
  generate
    for (p = 0; p < NPORTS; p = p + 1) begin : gPort
      reg [15:0] errCnt_r;
      wire countUp;
      assign countUp = parityErr[p] & parityCheckEn_r;
      // flag follows the count, which only falls on a clear: the flag
      // holds until then or until the threshold is written above the count, and a clear takes effect one cycle later
      assign parityFlag_nxt[p] = (errCnt_r >= threshold);
      always @(posedge ref_clk) begin
        if (srst) begin
          errCnt_r <= 16'h0000;
        end else if (parityFlagClr[p]) begin
          errCnt_r <= 16'h0000;
        end else if (countUp && errCnt_r != 16'hFFFF) begin
          errCnt_r <= errCnt_r + 16'h0001;
        end
      end
    end
  endgenerate

  // one process owns all flag bits, so each bit has a single driver
  always @(posedge ref_clk) begin
    if (srst) begin
      parityFlag_r <= {NPORTS{1'b0}};
    end else begin
      parityFlag_r <= parityFlag_nxt;
    end
  end

  ctrl_channel_watchdog #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) uWdog (
    .ref_clk(ref_clk),
    .srst(srst),
    .txnActive(ccTxnActive),
    .timeoutUnits(ctrlChannelTimeout_r),
    .wdogOff(ctrlChannelTimeoutOff_r),
    .abort_r(wdogAbort)
  );

  always @(posedge ref_clk) begin
    if (srst) begin
      ccAbort_r <= 1'b0;
    end else begin
      ccAbort_r <= wdogAbort;
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    readData_nxt = 8'h00;
    case (acAddr)
      `ADDR_GEN_CFG: begin
        readData_nxt[`BIT_PARITY_EN] = parityCheckEn_r;
      end
      `ADDR_REVISION: begin
        readData_nxt = {REV_ID, 4'h0};
      end
      `ADDR_STATUS: begin
        // reserved bits stay zero
        readData_nxt[`BIT_CKSUM_OK] = configChecksumOk_r;
        readData_nxt[`BIT_INIT_DONE] = initDone_r;
        readData_nxt[`BIT_PASS] = passLat_r;
        readData_nxt[`BIT_LOCK] = lockLat_r;
      end
      `ADDR_THR_HIGH: begin
        readData_nxt = thrHigh_r;
      end
      `ADDR_THR_LOW: begin
        readData_nxt = thrLow_r;
      end
      `ADDR_WDOG: begin
        readData_nxt = {ctrlChannelTimeout_r, ctrlChannelTimeoutOff_r};
      end
      `ADDR_HOST_CTL1: begin
        readData_nxt[`BIT_LOCAL_WR_DIS] = localWrDis_r;
      end
      default: begin
        readData_nxt = 8'h00;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      readData_r <= 8'h00;
      readValid_r <= 1'b0;
    end else begin
      readValid_r <= acRd;
      if (acRd) begin
        readData_r <= readData_nxt;
      end
    end
  end
endmodule // deser_shared_ctrl_status_regs

// *** inc/deser_regs_consts.vh ***
// register offsets, field positions, reset values and timing counts
// included by the register bank, the watchdog, the assertions and the bench
`ifndef DESER_REGS_CONSTS_VH
`define DESER_REGS_CONSTS_VH

`define ADDR_RESET_CTRL 8'h01
`define ADDR_GEN_CFG 8'h02
`define ADDR_REVISION 8'h03
`define ADDR_STATUS 8'h04
`define ADDR_THR_HIGH 8'h05
`define ADDR_THR_LOW 8'h06
`define ADDR_WDOG 8'h07
`define ADDR_HOST_CTL1 8'h08

`define BIT_ROM_RELOAD 2
`define BIT_PARITY_EN 1
`define BIT_CKSUM_OK 7
`define BIT_INIT_DONE 6
`define BIT_PASS 3
`define BIT_LOCK 2
`define BIT_WDOG_OFF 0
`define BIT_LOCAL_WR_DIS 7

`define RST_PARITY_EN 1'b1
`define RST_THR_HIGH 8'h01
`define RST_THR_LOW 8'h00
`define RST_WDOG_TIMEOUT 7'h7F
`define RST_WDOG_OFF 1'b0
`define RST_LOCAL_WR_DIS 1'b0

`define CLK_HZ 20000000
`define WDOG_UNIT_MS 2
`define WDOG_UNIT_CYC (`CLK_HZ / 1000 * `WDOG_UNIT_MS)

`endif

// *** logic/ctrl_channel_watchdog.v ***
// control-channel transaction watchdog, timeout in units of UNIT_CYCLES
// assumes txnActive is high for the whole life of one transaction
`include "deser_regs_consts.vh"
module ctrl_channel_watchdog #(
  parameter UNIT_CYCLES = `WDOG_UNIT_CYC
) (
  input wire ref_clk,
  input wire srst,
  input wire txnActive,
  input wire [6:0] timeoutUnits,
  input wire wdogOff,
  output reg abort_r
);
  reg [31:0] divCnt_r;
  reg [6:0] unitCnt_r;
  reg fired_r;
  wire unitTick;

  assign unitTick = (divCnt_r == UNIT_CYCLES - 1);

  always @(posedge ref_clk) begin
    if (srst) begin
      divCnt_r <= 32'h0000_0000;
      unitCnt_r <= 7'h00;
      fired_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      abort_r <= 1'b0;
      // idle or disabled: restart timing for the next transaction
      if (!txnActive || wdogOff) begin
        divCnt_r <= 32'h0000_0000;
        unitCnt_r <= 7'h00;
        fired_r <= 1'b0;
      end else if (!fired_r) begin
        divCnt_r <= unitTick ? 32'h0000_0000 : divCnt_r + 32'h0000_0001;
        if (unitTick) begin
          unitCnt_r <= unitCnt_r + 7'h01;
          // a zero timeout is illegal; it would fire after 128 units
          if (unitCnt_r + 7'h01 == timeoutUnits) begin
            abort_r <= 1'b1;
            fired_r <= 1'b1;
          end
        end
      end
    end
  end
endmodule // ctrl_channel_watchdog

// *** tb/deser_regs_asserts.sv ***
// port assertions for the shared register bank
// assumes binding onto the bank, register writes from the local port
`include "deser_regs_consts.vh"
module deser_regs_asserts #(
  parameter [3:0] REV_ID = 4'h5
) (
  input wire ref_clk,
  input wire srst,
  input wire locWr,
  input wire locRd,
  input wire [7:0] locAddr,
  input wire [7:0] locWdata,
  input wire remWr,
  input wire remLocal,
  input wire [7:0] readData_r,
  input wire passIn,
  input wire lockIn,
  input wire romLoadReq_r,
  input wire parityCheckEn_r,
  input wire passThru_r,
  input wire ccTxnActive,
  input wire ccAbort_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire stRd = locRd && locAddr == `ADDR_STATUS;
  property p_parityEn;
    locWr && locAddr == `ADDR_GEN_CFG |=>
      parityCheckEn_r == $past(locWdata[`BIT_PARITY_EN]);
  endproperty
  a_parityEn: assert property (p_parityEn) else $error("parity enable");
  property p_pass;
    stRd && $past(passIn) && !$past(srst) |=> readData_r[`BIT_PASS];
  endproperty
  a_pass: assert property (p_pass) else $error("pass not latched");
  property p_lock;
    stRd && $past(lockIn) && !$past(srst) |=> readData_r[`BIT_LOCK];
  endproperty
  a_lock: assert property (p_lock) else $error("lock not latched");
  property p_rsvd;
    stRd |=> readData_r[5:4] == 2'h0 && readData_r[1:0] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("status reserved");
  property p_rev;
    locRd && locAddr == `ADDR_REVISION |=> readData_r == {REV_ID, 4'h0};
  endproperty
  a_rev: assert property (p_rev) else $error("revision value");
  property p_thru;
    remWr && !remLocal && !locWr && !locRd |=> passThru_r;
  endproperty
  a_thru: assert property (p_thru) else $error("no pass-through");
  property p_reload;
    locWr && locAddr == `ADDR_RESET_CTRL && locWdata[`BIT_ROM_RELOAD]
      |=> romLoadReq_r;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");
  property p_wdog;
    $rose(ccTxnActive) |-> !ccAbort_r [*4];
  endproperty
  a_wdog: assert property (p_wdog) else $error("early abort");
endmodule // deser_regs_asserts

bind deser_shared_ctrl_status_regs deser_regs_asserts #(.REV_ID(REV_ID)) chk (
  .ref_clk, .srst, .locWr, .locRd, .locAddr, .locWdata, .remWr, .remLocal,
  .readData_r, .passIn, .lockIn, .romLoadReq_r, .parityCheckEn_r,
  .passThru_r, .ccTxnActive, .ccAbort_r);

// *** tb/rom_loader_model.sv ***
// rom loader stand-in: answers each load request after DELAY cycles
// assumes romLoadReq_r is a one-cycle pulse
module rom_loader_model #(
  parameter DELAY = 8
) (
  input wire ref_clk,
  input wire romLoadReq_r,
  input wire cksumGood,
  output logic romLoadDone,
  output logic romCksumOk
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial romLoadDone = 1'b0;
  // result valid only beside done; inverted otherwise so nothing leans on it
  assign romCksumOk = romLoadDone ? cksumGood : ~cksumGood;
  always @(posedge ref_clk) begin
    romLoadDone <= (cnt == 1);
    if (romLoadReq_r) begin
      cnt <= DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule // rom_loader_model

// *** tb/tb_deser_shared_ctrl_status_regs.sv ***
// self-checking bench for the shared register bank
// assumes the rom loader model and a 4-cycle watchdog unit
`include "deser_regs_consts.vh"
module tb_deser_shared_ctrl_status_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, srst = 1'b1, locWr = 1'b0, locRd = 1'b0;
  logic [7:0] locAddr = 8'h00, locWdata = 8'h00, remAddr = 8'h00;
  logic [7:0] remWdata = 8'h00, readData_r;
  logic remWr = 1'b0, remRd = 1'b0, remLocal = 1'b0, passIn = 1'b0;
  logic lockIn = 1'b0, ccTxnActive = 1'b0, cksumGood = 1'b1;
  logic [1:0] parityErr = 2'h0, parityFlagClr = 2'h0, parityFlag_r;
  logic readValid_r, remWrRejected_r, passThru_r, romLoadReq_r;
  logic romLoadDone, romCksumOk, parityCheckEn_r, ccAbort_r;
  int errors = 0, cmp_count = 0, n;
  // {write, address, write data, expected read}
  logic [31:0] rows [10] = '{32'h0005_0001, 32'h0006_0000,
    32'h0007_00FE, 32'h0008_0000, 32'h0002_0002,
    32'h0104_FFC0, 32'h0103_FF50, 32'h0106_3C3C,
    32'h0140_FF00, 32'h0102_0000};
  always #25 ref_clk = ~ref_clk;
  deser_shared_ctrl_status_regs #(.NPORTS(2), .UNIT_CYCLES(4),
    .REV_ID(4'h5)) dut (.ref_clk, .srst, .locWr, .locRd, .locAddr,
    .locWdata, .remWr, .remRd, .remLocal, .remAddr, .remWdata,
    .readData_r, .readValid_r, .remWrRejected_r, .passThru_r, .passIn,
    .lockIn, .romLoadDone, .romCksumOk, .romLoadReq_r, .parityErr,
    .parityFlagClr, .parityFlag_r, .parityCheckEn_r, .ccTxnActive,
    .ccAbort_r);
  rom_loader_model rom (.ref_clk, .romLoadReq_r, .cksumGood, .romLoadDone,
    .romCksumOk);
  task automatic give_verdict;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge ref_clk);
    {locWr, locAddr, locWdata} = {1'b1, a, d};
    @(negedge ref_clk);
    locWr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge ref_clk);
    {locRd, locAddr} = {1'b1, a};
    @(negedge ref_clk);
    locRd = 1'b0;
    chk({7'h00, readValid_r}, 8'h01);
    chk(readData_r, e);
  endtask
  task automatic rwr(input logic [7:0] a, d, input logic loc, rej, pas);
    @(negedge ref_clk);
    {remWr, remLocal, remAddr, remWdata} = {1'b1, loc, a, d};
    @(negedge ref_clk);
    remWr = 1'b0;
    chk({6'h00, remWrRejected_r, passThru_r}, {6'h00, rej, pas});
  endtask
  task automatic pe(input logic [1:0] m, e);
    @(negedge ref_clk);
    parityErr = m;
    @(negedge ref_clk);
    parityErr = 2'h0;
    @(negedge ref_clk);
    chk({6'h00, parityFlag_r}, {6'h00, e});
  endtask
  task automatic waitLoad;
    n = 0;
    while (romLoadDone !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 50) begin
      errors++;
      give_verdict;
    end
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    srst = 1'b0;
    chk({7'h00, parityCheckEn_r}, 8'h01);
    waitLoad;
    for (int i = 0; i < 10; i++) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    {passIn, lockIn} = 2'b11;
    @(negedge ref_clk);
    rd(`ADDR_STATUS, 8'hCC);
    {passIn, lockIn} = 2'b00;
    rd(`ADDR_STATUS, 8'hCC);
    rd(`ADDR_STATUS, 8'hC0);
    wr(`ADDR_HOST_CTL1, 8'h80);
    rwr(`ADDR_THR_HIGH, 8'h77, 1'b1, 1'b1, 1'b0);
    rwr(`ADDR_THR_HIGH, 8'h77, 1'b0, 1'b0, 1'b1);
    rd(`ADDR_THR_HIGH, 8'h01);
    wr(`ADDR_HOST_CTL1, 8'h00);
    rwr(`ADDR_THR_HIGH, 8'h00, 1'b1, 1'b0, 1'b0);
    @(negedge ref_clk);
    {remRd, remLocal, remAddr} = {1'b1, 1'b1, `ADDR_THR_HIGH};
    @(negedge ref_clk);
    remRd = 1'b0;
    chk(readData_r, 8'h00);
    wr(`ADDR_THR_LOW, 8'h03);
    repeat (3) pe(2'b10, 2'b00);
    wr(`ADDR_GEN_CFG, 8'h02);
    pe(2'b11, 2'b00);
    pe(2'b01, 2'b00);
    pe(2'b11, 2'b01);
    pe(2'b10, 2'b11);
    parityFlagClr = 2'b01;
    @(negedge ref_clk);
    parityFlagClr = 2'b00;
    repeat (2) @(negedge ref_clk);
    chk({6'h00, parityFlag_r}, 8'h02);
    wr(`ADDR_WDOG, 8'h04);
    ccTxnActive = 1'b1;
    n = 0;
    while (ccAbort_r !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    ccTxnActive = 1'b0;
    chk(8'(n >= 8 && n <= 11), 8'h01);
    if (n == 40) give_verdict;
    wr(`ADDR_WDOG, 8'h05);
    ccTxnActive = 1'b1;
    n = 0;
    repeat (30) begin
      @(negedge ref_clk);
      n += ccAbort_r;
    end
    ccTxnActive = 1'b0;
    chk(8'(n), 8'h00);
    cksumGood = 1'b0;
    wr(`ADDR_RESET_CTRL, 8'h04);
    rd(`ADDR_STATUS, 8'h00);
    waitLoad;
    rd(`ADDR_STATUS, 8'h40);
    // mid-run reset: registers and flags back to their reset values
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    chk({6'h00, parityFlag_r}, 8'h00);
    rd(`ADDR_STATUS, 8'h00);
    rd(`ADDR_THR_HIGH, 8'h01);
    rd(`ADDR_WDOG, 8'hFE);
    give_verdict;
  end
endmodule // tb_deser_shared_ctrl_status_regs
